// >>> shared/ctm_pkg.sv
// constants for the compact timer with compare output
// assumes a 32-bit apb slave with byte-wide registers in the low lanes
package compact_timer_pkg;

    // register byte addresses
    localparam logic [7:0] OFS_CONTROL_ZERO = 8'h00;
    localparam logic [7:0] OFS_CONTROL_ONE = 8'h04;
    localparam logic [7:0] OFS_COUNTER_LOW = 8'h08;
    localparam logic [7:0] OFS_COUNTER_HIGH = 8'h0C;
    localparam logic [7:0] OFS_COMPARE_A_LOW = 8'h10;
    localparam logic [7:0] OFS_COMPARE_A_HIGH = 8'h14;
    localparam logic [7:0] OFS_MATCH_STATUS = 8'h18;

    // control zero fields
    localparam int CZ_PERIOD_LSB = 0;
    localparam int CZ_RUN_BIT = 3;
    localparam int CZ_CLKSEL_LSB = 4;

    // control one fields (timer_control_one)
    localparam int CO_CLEAR_SRC_BIT = 0;
    localparam int CO_SWAP_BIT = 1;
    localparam int CO_INVERT_BIT = 2;
    localparam int CO_INIT_LEVEL_BIT = 3;
    localparam int CO_ACTION_LSB = 4;
    localparam int CO_MODE_LSB = 6;

    // status fields, write one to clear
    localparam int ST_MATCH_A_BIT = 0;
    localparam int ST_MATCH_P_BIT = 1;

    // reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [9:0] COMPARE_A_RESET = 10'h000;
    localparam logic [9:0] COUNTER_RESET = 10'h000;

    // counter geometry
    localparam int COUNT_W = 10;
    localparam int PERIOD_W = 3;
    localparam int PERIOD_LSB = 7;

    // counting clock dividers
    localparam int DIV_SYS_QUARTER = 4;
    localparam int DIV_HIGH_16 = 16;
    localparam int DIV_HIGH_64 = 64;
    localparam int DIV_SUB_DEFAULT = 256;

    typedef enum logic [1:0]
    {
        MODE_COMPARE = 2'b00,
        MODE_UNDEFINED = 2'b01,
        MODE_PWM = 2'b10,
        MODE_TIMER = 2'b11
    } mode_t;

    typedef enum logic [1:0]
    {
        ACT_KEEP = 2'b00,
        ACT_LOW = 2'b01,
        ACT_HIGH = 2'b10,
        ACT_TOGGLE = 2'b11
    } action_t;

endpackage

// >>> rtl/count_tick_gen.sv
// counting clock selector: one-cycle tick per enabled counting edge
// assumes count_edge_i is synchronous to sys_clk_i
module count_tick_gen
    import compact_timer_pkg::*;
#(
    parameter int SUB_DIV = DIV_SUB_DEFAULT
)
(
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic [2:0] clk_select_i,
    input wire logic count_edge_i,
    output logic tick_o
);

    logic [7:0] div_ff;
    logic edge_prev_ff;
    logic tick_ff;
    logic nxt_tick;

    // free-running divider shared by all divided sources
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            div_ff <= 8'h00;
        else
            div_ff <= div_ff + 8'h01;
    end

    // previous edge-source level for edge detection
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            edge_prev_ff <= 1'b0;
        else
            edge_prev_ff <= count_edge_i;
    end

    // pick the tick for the selected source
    always_comb
    begin
        case (clk_select_i)
            3'b000: nxt_tick = (div_ff[1:0] == 2'(DIV_SYS_QUARTER - 1));
            3'b001: nxt_tick = 1'b1;
            3'b010: nxt_tick = (div_ff[3:0] == 4'(DIV_HIGH_16 - 1));
            3'b011: nxt_tick = (div_ff[5:0] == 6'(DIV_HIGH_64 - 1));
            3'b110: nxt_tick = count_edge_i & ~edge_prev_ff;
            3'b111: nxt_tick = ~count_edge_i & edge_prev_ff;
            default: nxt_tick = (div_ff == 8'(SUB_DIV - 1));
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            tick_ff <= 1'b0;
        else
            tick_ff <= nxt_tick;
    end

    assign tick_o = tick_ff;

endmodule

// >>> rtl/compact_timer_unit.sv
// compact 10-bit timer with compare a and period p comparators, apb registers
// assumes an apb3 master on sys_clk_i; count_edge_i synchronous to the clock
module compact_timer_unit
    import compact_timer_pkg::*;
#(
    parameter int SUB_DIV = DIV_SUB_DEFAULT
)
(
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic count_edge_i,
    output logic timer_output_o,
    output logic match_a_event_o,
    output logic match_p_event_o
);

    logic [7:0] control_zero_ff;
    logic [7:0] control_one_ff;
    logic [9:0] compare_a_value_ff;
    logic [9:0] count_ff;
    logic [9:0] nxt_count;
    logic run_prev_ff;
    logic match_a_flag_ff;
    logic match_p_flag_ff;
    logic out_level_ff;
    logic nxt_out_level;
    logic timer_output_ff;
    logic match_a_event_ff;
    logic match_p_event_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] rd_value;
    logic rd_hit;
    logic tick;
    logic counter_run;
    logic run_rise;
    logic [2:0] period_compare_value;
    logic clear_source_select;
    logic period_duty_swap;
    logic output_invert;
    logic output_initial_level;
    action_t action;
    mode_t mode;
    logic [9:0] count_plus;
    logic step;
    logic hit_a;
    logic hit_p;
    logic raise_a;
    logic raise_p;
    logic clear_by_a;
    logic [10:0] duty_limit;
    logic pwm_active;
    logic wr_en;
    logic status_wr;

    // decoded control fields
    assign counter_run = control_zero_ff[CZ_RUN_BIT];
    assign period_compare_value = control_zero_ff[CZ_PERIOD_LSB +: PERIOD_W];
    assign clear_source_select = control_one_ff[CO_CLEAR_SRC_BIT];
    assign period_duty_swap = control_one_ff[CO_SWAP_BIT];
    assign output_invert = control_one_ff[CO_INVERT_BIT];
    assign output_initial_level = control_one_ff[CO_INIT_LEVEL_BIT];
    assign action = action_t'(control_one_ff[CO_ACTION_LSB +: 2]);
    assign mode = mode_t'(control_one_ff[CO_MODE_LSB +: 2]);

    // counting clock source
    count_tick_gen #(
        .SUB_DIV(SUB_DIV)
    ) u_tick (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .clk_select_i(control_zero_ff[CZ_CLKSEL_LSB +: 3]),
        .count_edge_i(count_edge_i),
        .tick_o(tick)
    );

    // apb access strobes, run rising edge and counting step
    assign wr_en = psel_i & penable_i & pready_ff & pwrite_i;
    assign status_wr = wr_en & (paddr_i == OFS_MATCH_STATUS);
    assign run_rise = counter_run & ~run_prev_ff;
    assign step = counter_run & ~run_rise & tick;

    // comparators on the incremented count
    assign count_plus = count_ff + 10'h001;
    assign hit_p = (count_plus[9:PERIOD_LSB] == period_compare_value) && (count_plus[PERIOD_LSB-1:0] == 7'h00);
    assign hit_a = (count_plus == compare_a_value_ff);

    // clearing comparator choice per mode
    always_comb
    begin
        if (mode == MODE_PWM)
            clear_by_a = period_duty_swap;
        else
            clear_by_a = clear_source_select;
    end

    // flag raising conditions
    always_comb
    begin
        raise_a = step & hit_a;
        raise_p = step & hit_p;
        if (mode != MODE_PWM && clear_source_select)
        begin
            raise_p = 1'b0;
            if (compare_a_value_ff == COMPARE_A_RESET)
                raise_a = 1'b0;
        end
        else if (mode != MODE_PWM)
        begin
            raise_a = step & hit_a;
            raise_p = step & hit_p;
        end
    end

    // next counter value; overflow clears naturally only when the selected clearing value (period or compare a) is zero
    always_comb
    begin
        nxt_count = count_ff;
        if (run_rise)
            nxt_count = COUNTER_RESET;
        else if (step)
        begin
            if (clear_by_a && hit_a)
                nxt_count = COUNTER_RESET;
            else if (!clear_by_a && hit_p)
                nxt_count = COUNTER_RESET;
            else
                nxt_count = count_plus;
        end
    end

    // counter register
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            count_ff <= COUNTER_RESET;
        else
            count_ff <= nxt_count;
    end

    // run bit history for edge detection
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            run_prev_ff <= 1'b0;
        else
            run_prev_ff <= counter_run;
    end

    // pwm duty threshold; a zero period value stands for 1024
    always_comb
    begin
        if (period_duty_swap)
            duty_limit = (period_compare_value == 3'h0) ? 11'h400 : {1'b0, period_compare_value, 7'h00};
        else
            duty_limit = {1'b0, compare_a_value_ff};
        pwm_active = ({1'b0, count_ff} < duty_limit);
    end

    // output level before inversion
    always_comb
    begin
        nxt_out_level = out_level_ff;
        if (run_rise && (mode == MODE_COMPARE || mode == MODE_PWM))
            nxt_out_level = output_initial_level;
        else if (mode == MODE_COMPARE && raise_a)
        begin
            case (action)
                ACT_KEEP: nxt_out_level = out_level_ff;
                ACT_LOW: nxt_out_level = 1'b0;
                ACT_HIGH: nxt_out_level = 1'b1;
                ACT_TOGGLE: nxt_out_level = ~out_level_ff;
                default: nxt_out_level = out_level_ff;
            endcase
        end
        else if (mode == MODE_PWM)
        begin
            case (action)
                ACT_KEEP: nxt_out_level = ~output_initial_level;
                ACT_LOW: nxt_out_level = output_initial_level;
                ACT_HIGH: nxt_out_level = pwm_active ? output_initial_level : ~output_initial_level;
                default: nxt_out_level = ~output_initial_level;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            out_level_ff <= 1'b0;
        else
            out_level_ff <= nxt_out_level;
    end

    // pin level; timer and undefined modes hold the pin
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            timer_output_ff <= 1'b0;
        else if (mode == MODE_COMPARE || mode == MODE_PWM)
            timer_output_ff <= nxt_out_level ^ output_invert;
    end

    // sticky match flags; a new match wins over a clear
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            match_a_flag_ff <= 1'b0;
            match_p_flag_ff <= 1'b0;
        end
        else
        begin
            match_a_flag_ff <= raise_a | (match_a_flag_ff & ~(status_wr & pwdata_i[ST_MATCH_A_BIT]));
            match_p_flag_ff <= raise_p | (match_p_flag_ff & ~(status_wr & pwdata_i[ST_MATCH_P_BIT]));
        end
    end

    // one-cycle match pulses for the interrupt logic outside
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            match_a_event_ff <= 1'b0;
            match_p_event_ff <= 1'b0;
        end
        else
        begin
            match_a_event_ff <= raise_a;
            match_p_event_ff <= raise_p;
        end
    end

    // software-written registers
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            control_zero_ff <= CONTROL_RESET;
            control_one_ff <= CONTROL_RESET;
            compare_a_value_ff <= COMPARE_A_RESET;
        end
        else if (wr_en)
        begin
            case (paddr_i)
                OFS_CONTROL_ZERO: control_zero_ff <= {1'b0, pwdata_i[6:0]};
                OFS_CONTROL_ONE: control_one_ff <= pwdata_i[7:0];
                OFS_COMPARE_A_LOW: compare_a_value_ff[7:0] <= pwdata_i[7:0];
                OFS_COMPARE_A_HIGH: compare_a_value_ff[9:8] <= pwdata_i[1:0];
                default: ;
            endcase
        end
    end

    // read mux; unused upper bits read zero
    always_comb
    begin
        rd_value = 32'h0000_0000;
        rd_hit = 1'b1;
        case (paddr_i)
            OFS_CONTROL_ZERO: rd_value[7:0] = control_zero_ff;
            OFS_CONTROL_ONE: rd_value[7:0] = control_one_ff;
            OFS_COUNTER_LOW: rd_value[7:0] = count_ff[7:0];
            OFS_COUNTER_HIGH: rd_value[1:0] = count_ff[9:8];
            OFS_COMPARE_A_LOW: rd_value[7:0] = compare_a_value_ff[7:0];
            OFS_COMPARE_A_HIGH: rd_value[1:0] = compare_a_value_ff[9:8];
            OFS_MATCH_STATUS:
            begin
                rd_value[ST_MATCH_A_BIT] = match_a_flag_ff;
                rd_value[ST_MATCH_P_BIT] = match_p_flag_ff;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // apb answer: ready in the first access cycle
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end
        else
        begin
            pready_ff <= psel_i & ~penable_i;
            pslverr_ff <= psel_i & ~penable_i & ~rd_hit;
            prdata_ff <= (psel_i & ~penable_i & ~pwrite_i) ? rd_value : 32'h0000_0000;
        end
    end

    assign prdata_o = prdata_ff;
    assign pready_o = pready_ff;
    assign pslverr_o = pslverr_ff;
    assign timer_output_o = timer_output_ff;
    assign match_a_event_o = match_a_event_ff;
    assign match_p_event_o = match_p_event_ff;

    // checks
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_run_rise;
        counter_run && !run_prev_ff;
    endsequence

    sequence s_counter_zero;
        count_ff == COUNTER_RESET;
    endsequence

    a_run_clears_count: assert property (s_run_rise |=> s_counter_zero)
        else $error("counter not zero after run rising edge");

    a_stop_keeps_count: assert property (!counter_run && !$past(run_rise) |=> $stable(count_ff))
        else $error("counter moved while stopped");

    a_run_init_level: assert property ((s_run_rise and mode == MODE_COMPARE)
        |=> timer_output_o == (output_initial_level ^ output_invert))
        else $error("output not at initial level after run rising edge");

    a_no_p_flag: assert property (mode == MODE_COMPARE && clear_source_select && !$past(match_p_flag_ff)
        && !match_p_flag_ff |=> !match_p_flag_ff)
        else $error("match p flag raised with clear source high");

    a_zero_a_no_flag: assert property (mode == MODE_COMPARE && clear_source_select
        && compare_a_value_ff == COMPARE_A_RESET |-> !raise_a)
        else $error("match a raised with zero compare value");

    a_cmp_output_cause: assert property (mode == MODE_COMPARE && !run_rise && !raise_a
        && $stable(control_one_ff) |=> $stable(timer_output_o))
        else $error("compare output changed without match a");

    a_toggle_on_match: assert property (mode == MODE_COMPARE && raise_a && action == ACT_TOGGLE && !run_rise
        && $stable(control_one_ff) |=> timer_output_o != $past(timer_output_o))
        else $error("output did not toggle on match a");

    a_clear_on_a: assert property (step && mode == MODE_COMPARE && clear_source_select && hit_a
        |=> s_counter_zero)
        else $error("counter not cleared on match a");

    a_p_match_period: assert property (raise_p |-> count_plus[PERIOD_LSB-1:0] == 7'h00)
        else $error("match p off a 128-count boundary");

    a_flag_sticky: assert property (match_a_flag_ff && !status_wr ##1 !status_wr
        |-> match_a_flag_ff)
        else $error("match a flag dropped without clear");

    a_pwm_forced_level: assert property (mode == MODE_PWM && action == ACT_LOW && !run_rise
        && $stable(control_one_ff) ##1 $stable(control_one_ff)
        |-> timer_output_o == (output_initial_level ^ output_invert))
        else $error("pwm forced active level wrong");

    a_counter_read: assert property (psel_i && !penable_i && !pwrite_i && paddr_i == OFS_COUNTER_HIGH
        |=> prdata_o[31:2] == 30'h0 && pready_o)
        else $error("counter high read wrong");

endmodule

// >>> tb/compact_timer_unit_tb.sv
// self-checking bench for the compact timer unit: apb registers, compare, pwm, timer modes
// assumes the unit at 20 MHz, counting clock select 001 (one tick per cycle), count edge held low
module compact_timer_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import compact_timer_pkg::*;

    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pin;
    logic ev_a;
    logic ev_p;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;

    compact_timer_unit #(.SUB_DIV(4)) dut (
        .sys_clk_i(clk), .resetn_i(resetn), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .count_edge_i(1'b0), .timer_output_o(pin), .match_a_event_o(ev_a), .match_p_event_o(ev_p)
    );

    // 50 ns clock
    always #25 clk = ~clk;

    // hang guard
    always @(posedge clk)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            mismatches++;
            stop_test();
        end
    end

    task stop_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer: setup, access held until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (n >= 16)
            mismatches++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, {24'h000000, d}, r, e);
    endtask

    task rdv(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        rdv(a, r);
        chk(r, exp);
    endtask

    function logic [7:0] c1(input logic [1:0] m, input logic [1:0] a, input logic l, v, s, c);
        return {m, a, l, v, s, c};
    endfunction

    // stop, configure, clear flags, run with select 001
    task start(input logic [7:0] ctl, input logic [9:0] ca, input logic [2:0] per);
        wr(OFS_CONTROL_ZERO, 8'h10);
        wr(OFS_CONTROL_ONE, ctl);
        wr(OFS_COMPARE_A_LOW, ca[7:0]);
        wr(OFS_COMPARE_A_HIGH, {6'h00, ca[9:8]});
        wr(OFS_MATCH_STATUS, 8'h03);
        wr(OFS_CONTROL_ZERO, {5'h03, per});
    endtask

    task wait_ev(input logic which, input int lim, output int n);
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (((which ? ev_p : ev_a) !== 1'b1) && n < lim);
    endtask

    // reset values, read-only counter, high-byte masking, unmapped place
    task t_regs;
        logic [31:0] r;
        logic e;
        rdchk(OFS_COUNTER_LOW, 32'h0);
        rdchk(OFS_COUNTER_HIGH, 32'h0);
        rdchk(OFS_COMPARE_A_LOW, 32'h0);
        rdchk(OFS_COMPARE_A_HIGH, 32'h0);
        wr(OFS_COMPARE_A_LOW, 8'hA5);
        wr(OFS_COMPARE_A_HIGH, 8'hFF);
        rdchk(OFS_COMPARE_A_LOW, 32'hA5);
        rdchk(OFS_COMPARE_A_HIGH, 32'h3);
        wr(OFS_COUNTER_LOW, 8'h55);
        rdchk(OFS_COUNTER_LOW, 32'h0);
        apb(1'b0, 8'h3C, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
    endtask

    // every action, initial level and invert in compare mode
    task t_actions;
        logic [1:0] a;
        logic l;
        logic v;
        logic exp;
        int n;
        for (int i = 0; i < 16; i++)
        begin
            a = i[1:0];
            l = i[2];
            v = i[3];
            start(c1(MODE_COMPARE, a, l, v, 1'b0, 1'b1), 10'h003, 3'h0);
            @(negedge clk);
            @(negedge clk);
            chk({31'h0, pin}, {31'h0, l ^ v});
            wait_ev(1'b0, 40, n);
            exp = (a == 2'h0) ? l : (a == 2'h1) ? 1'b0 : (a == 2'h2) ? 1'b1 : ~l;
            chk({31'h0, pin}, {31'h0, exp ^ v});
        end
    endtask

    // spacing of match events, flags and pin held
    task t_period(input logic [7:0] ctl, input logic [9:0] ca, input logic [2:0] per, input logic which,
                  input int sp, input logic [1:0] st);
        int n;
        start(ctl, ca, per);
        wait_ev(which, 1100, n);
        wait_ev(which, 1100, n);
        chk(n, sp);
        rdchk(OFS_MATCH_STATUS, {30'h0, st});
        chk({31'h0, pin}, {31'h0, ctl[CO_INIT_LEVEL_BIT]});
    endtask

    // active cycles of the pin over one period window
    task t_pwm(input logic [7:0] ctl, input logic [9:0] ca, input int win, input int exp_n);
        int n;
        start(ctl, ca, 3'h1);
        repeat (300) @(negedge clk);
        n = 0;
        repeat (win)
        begin
            @(negedge clk);
            if (pin === (ctl[CO_INIT_LEVEL_BIT] ^ ctl[CO_INVERT_BIT]))
                n++;
        end
        chk(n, exp_n);
    endtask

    // timer mode leaves the pin alone while flags still rise
    task t_timer;
        logic p0;
        p0 = pin;
        start(c1(MODE_TIMER, 2'h3, 1'b1, 1'b1, 1'b0, 1'b1), 10'h003, 3'h0);
        repeat (40) @(negedge clk);
        chk({31'h0, pin}, {31'h0, p0});
        rdchk(OFS_MATCH_STATUS, 32'h1);
    endtask

    // stepping, stop keeps count, restart zeroes it
    task t_hold;
        logic [31:0] r1;
        logic [31:0] r2;
        start(c1(MODE_COMPARE, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1), 10'h3FF, 3'h0);
        repeat (20) @(negedge clk);
        rdv(OFS_COUNTER_LOW, r1);
        rdv(OFS_COUNTER_LOW, r2);
        chk(r2 - r1, 32'h3);
        wr(OFS_CONTROL_ZERO, 8'h10);
        rdv(OFS_COUNTER_LOW, r1);
        repeat (10) @(negedge clk);
        rdv(OFS_COUNTER_LOW, r2);
        chk(r2, r1);
        chk(r1 > 32'h10, 32'h1);
        wr(OFS_CONTROL_ZERO, 8'h18);
        rdv(OFS_COUNTER_LOW, r2);
        chk(r2 < 32'h8, 32'h1);
    endtask

    // main sequence
    initial
    begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        t_regs();
        t_actions();
        t_period(c1(MODE_COMPARE, 2'h3, 1'b1, 1'b0, 1'b0, 1'b0), 10'd200, 3'h1, 1'b1, 128, 2'h2);
        t_period(c1(MODE_COMPARE, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0), 10'd5, 3'h1, 1'b1, 128, 2'h3);
        t_period(c1(MODE_COMPARE, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1), 10'd300, 3'h1, 1'b0, 300, 2'h1);
        t_period(c1(MODE_COMPARE, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1), 10'd0, 3'h0, 1'b0, 1100, 2'h0);
        t_pwm(c1(MODE_PWM, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0), 10'd32, 128, 0);
        t_pwm(c1(MODE_PWM, 2'h1, 1'b0, 1'b1, 1'b0, 1'b0), 10'd32, 128, 128);
        t_pwm(c1(MODE_PWM, 2'h2, 1'b1, 1'b0, 1'b0, 1'b1), 10'd32, 128, 32);
        t_pwm(c1(MODE_PWM, 2'h2, 1'b1, 1'b0, 1'b1, 1'b0), 10'd255, 255, 128);
        t_pwm(c1(MODE_PWM, 2'h3, 1'b1, 1'b0, 1'b0, 1'b0), 10'd32, 128, 0);
        t_timer();
        t_hold();
        stop_test();
    end
endmodule
